// >>> logic/nsfb_regs.vh
`ifndef NSFB_REGS_VH
`define NSFB_REGS_VH
// Operand and datapath widths
`define NSFB_ADDR_W 32
`define NSFB_DATA_W 32
`define NSFB_STORE_W 16
`define NSFB_LEVEL_W 5
// Deepest lexical level accepted
`define NSFB_LEVEL_MAX 5'h1F
// Doubleword step for pushes and display walk
`define NSFB_DWORD 32'h00000004
// Segment select codes on memory requests
`define NSFB_SEG_DATA 2'h0
`define NSFB_SEG_STACK 2'h1
// Reset values of the frame base and stack pointer
`define NSFB_FB_RESET 32'h00000000
`define NSFB_SP_RESET 32'h00000000
`endif

// >>> logic/nsfb_sub4.v
`timescale 1ns/1ps
`include "nsfb_regs.vh"
// ------------------------------------------------------------
// Doubleword decrement, shared by push and display walk
// ------------------------------------------------------------
module nsfb_sub4 (
   input wire [31:0] value,
   output wire [31:0] result
);
   assign result = value - `NSFB_DWORD;
endmodule

// >>> logic/nsfb_operand_latch.v
`timescale 1ns/1ps
// ------------------------------------------------------------
// Operand capture at instruction start
// ------------------------------------------------------------
module nsfb_operand_latch (
   input wire clock,
   input wire resetn,
   input wire load,
   input wire [15:0] storageIn,
   input wire [4:0] levelIn,
   output reg [15:0] storage_reg,
   output reg [4:0] level_reg
);
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         storage_reg <= 16'h0000;
         level_reg <= 5'h00;
      end else if (load) begin
         storage_reg <= storageIn;
         level_reg <= levelIn;
      end
   end
endmodule

// >>> logic/nsfb_frame_builder.v
`timescale 1ns/1ps
// What this block does
// R1: A start takes a local storage byte count and a nesting depth from 0 to 31.
// R2: The depth sets how many display pointers are copied from the old frame.
// R3: After the display, the stack pointer drops by the storage count.
// R4: At the end the frame base points at the display's first, highest doubleword.
// R5: Depth 0 pushes the frame base, copies stack pointer to it and reserves storage.
// R6: Nonzero depth walks the old display depth-1 times, then pushes the saved frame value.
// R7: Depth 1 copies no old entries, pushing only its own frame value.
// R8: The first display doubleword is the pointer to the previous frame.
// R9: Accesses based on the frame base use the stack segment.
// R10: The depth never touches privilege level checks.
// R11: Each push lowers the stack pointer by four, then writes there.
`include "nsfb_regs.vh"
module nsfb_frame_builder (
   input wire clock,
   input wire resetn,
   input wire start,
   input wire [15:0] storageIn,
   input wire [4:0] levelIn,
   input wire loadRegs,
   input wire [31:0] loadFrameBase,
   input wire [31:0] loadStackPtr,
   input wire memReady,
   input wire [31:0] memReadData,
   input wire [1:0] cplIn,
   input wire [1:0] ioplIn,
   output reg busy,
   output reg done,
   output reg memWrite,
   output reg memRead,
   output reg [31:0] memAddr,
   output reg [31:0] memWriteData,
   output reg [1:0] memSegment,
   output reg [31:0] frameBaseOut,
   output reg [31:0] stackPtrOut,
   output reg [1:0] cplOut,
   output reg [1:0] ioplOut
);
   // ------------------------------------------------------------
   // States
   // ------------------------------------------------------------
   localparam S_IDLE = 7'b0000001;
   localparam S_PUSHFB = 7'b0000010;
   localparam S_RDWALK = 7'b0000100;
   localparam S_PUSHWALK = 7'b0001000;
   localparam S_PUSHFRAME = 7'b0010000;
   localparam S_FINISH = 7'b0100000;
   localparam S_DONE = 7'b1000000;

   reg [6:0] state_reg;
   reg [6:0] state_next;
   reg [31:0] frame_base_reg;
   reg [31:0] stack_pointer_reg;
   reg [31:0] saved_frame_value;
   reg [4:0] walkCount_reg;
   wire [15:0] storageVal;
   wire [4:0] levelVal;
   wire [31:0] spMinus4;
   wire [31:0] fbMinus4;
   wire opLoad;

   // ------------------------------------------------------------
   // Count decodes shared by sequencing and datapath
   // ------------------------------------------------------------
   function countIsZero;
      input [4:0] cnt;
      begin
         countIsZero = (cnt == 5'h00);
      end
   endfunction

   function countIsOne;
      input [4:0] cnt;
      begin
         countIsOne = (cnt == 5'h01);
      end
   endfunction

   assign opLoad = start && (state_reg == S_IDLE);

   nsfb_operand_latch uLatch (
      .clock(clock),
      .resetn(resetn),
      .load(opLoad),
      .storageIn(storageIn),
      .levelIn(levelIn),
      .storage_reg(storageVal),
      .level_reg(levelVal)
   ); // R1

   nsfb_sub4 uSpDec (
      .value(stack_pointer_reg),
      .result(spMinus4)
   );

   nsfb_sub4 uFbDec (
      .value(frame_base_reg),
      .result(fbMinus4)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (start) begin
               state_next = S_PUSHFB;
            end
         end
         S_PUSHFB: begin
            if (memReady) begin
               if (countIsZero(levelVal)) begin
                  state_next = S_FINISH; // R5
               end else if (countIsOne(levelVal)) begin
                  state_next = S_PUSHFRAME; // R7
               end else begin
                  state_next = S_RDWALK; // R2
               end
            end
         end
         S_RDWALK: begin
            if (memReady) begin
               state_next = S_PUSHWALK;
            end
         end
         S_PUSHWALK: begin
            if (memReady) begin
               if (countIsOne(walkCount_reg)) begin
                  state_next = S_PUSHFRAME; // R6
               end else begin
                  state_next = S_RDWALK;
               end
            end
         end
         S_PUSHFRAME: begin
            if (memReady) begin
               state_next = S_FINISH;
            end
         end
         S_FINISH: begin
            state_next = S_DONE;
         end
         S_DONE: begin
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // State register and privilege pass-through
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= S_IDLE;
         cplOut <= 2'h0;
         ioplOut <= 2'h0;
      end else begin
         state_reg <= state_next;
         // Registered straight through, so depth has no path into them
         cplOut <= cplIn; // R10
         ioplOut <= ioplIn; // R10
      end
   end

   // ------------------------------------------------------------
   // Frame base, stack pointer and walk count
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         frame_base_reg <= `NSFB_FB_RESET;
         stack_pointer_reg <= `NSFB_SP_RESET;
         saved_frame_value <= 32'h00000000;
         walkCount_reg <= 5'h00;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (loadRegs) begin
                  frame_base_reg <= loadFrameBase;
                  stack_pointer_reg <= loadStackPtr;
               end
               if (start) begin
                  stack_pointer_reg <= spMinus4; // R11
                  saved_frame_value <= spMinus4;
                  walkCount_reg <= levelIn - 5'h01;
               end
            end
            S_PUSHFB: begin
               if (memReady) begin
                  if (countIsOne(levelVal)) begin
                     stack_pointer_reg <= spMinus4; // R11
                  end else if (!countIsZero(levelVal)) begin
                     frame_base_reg <= fbMinus4; // R6
                  end
               end
            end
            S_RDWALK: begin
               if (memReady) begin
                  stack_pointer_reg <= spMinus4; // R11
               end
            end
            S_PUSHWALK: begin
               if (memReady) begin
                  walkCount_reg <= walkCount_reg - 5'h01;
                  if (countIsOne(walkCount_reg)) begin
                     stack_pointer_reg <= spMinus4; // R11
                  end else begin
                     frame_base_reg <= fbMinus4; // R6
                  end
               end
            end
            S_FINISH: begin
               frame_base_reg <= saved_frame_value; // R4
               stack_pointer_reg <= stack_pointer_reg - {16'h0000, storageVal}; // R3
            end
            default: begin
               walkCount_reg <= walkCount_reg;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Memory requests
   // ------------------------------------------------------------
   // A request is held until memReady; address and data are set on entry
   // so they stay steady for the whole handshake.
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         memWrite <= 1'b0;
         memRead <= 1'b0;
         memAddr <= 32'h00000000;
         memWriteData <= 32'h00000000;
         memSegment <= `NSFB_SEG_STACK;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (start) begin
                  memWrite <= 1'b1;
                  memAddr <= spMinus4; // R11
                  memWriteData <= frame_base_reg; // R8
                  memSegment <= `NSFB_SEG_STACK;
               end
            end
            S_PUSHFB: begin
               if (memReady) begin
                  if (countIsOne(levelVal)) begin
                     memAddr <= spMinus4; // R11
                     memWriteData <= saved_frame_value; // R7
                  end else begin
                     memWrite <= 1'b0;
                     if (!countIsZero(levelVal)) begin
                        memRead <= 1'b1;
                        memAddr <= fbMinus4; // R6
                        memSegment <= `NSFB_SEG_STACK; // R9
                     end
                  end
               end
            end
            S_RDWALK: begin
               if (memReady) begin
                  memRead <= 1'b0;
                  memWrite <= 1'b1;
                  memAddr <= spMinus4; // R11
                  memWriteData <= memReadData; // R2
               end
            end
            S_PUSHWALK: begin
               if (memReady) begin
                  if (countIsOne(walkCount_reg)) begin
                     memAddr <= spMinus4; // R11
                     memWriteData <= saved_frame_value; // R6
                  end else begin
                     memWrite <= 1'b0;
                     memRead <= 1'b1;
                     memAddr <= fbMinus4; // R6
                  end
               end
            end
            S_PUSHFRAME: begin
               if (memReady) begin
                  memWrite <= 1'b0;
               end
            end
            default: begin
               memSegment <= `NSFB_SEG_STACK; // R9
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Completion status
   // ------------------------------------------------------------
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         busy <= 1'b0;
         done <= 1'b0;
         frameBaseOut <= `NSFB_FB_RESET;
         stackPtrOut <= `NSFB_SP_RESET;
      end else begin
         case (state_reg)
            S_IDLE: begin
               busy <= start;
               done <= 1'b0;
            end
            S_DONE: begin
               busy <= 1'b0;
               done <= 1'b1;
               frameBaseOut <= frame_base_reg; // R4
               stackPtrOut <= stack_pointer_reg; // R3
            end
            default: begin
               busy <= 1'b1;
               done <= 1'b0;
            end
         endcase
      end
   end
endmodule

// >>> tb/nsfb_frame_builder_monitor.sv
`timescale 1ns/1ps
module nsfb_frame_builder_monitor (
   input wire clock,
   input wire resetn,
   input wire start,
   input wire busy,
   input wire done,
   input wire memWrite,
   input wire memRead,
   input wire memReady,
   input wire [31:0] memAddr,
   input wire [1:0] memSegment,
   input wire [1:0] cplIn,
   input wire [1:0] ioplIn,
   input wire [1:0] cplOut,
   input wire [1:0] ioplOut
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   seg_stack_a: assert property (memSegment == 2'h1)
      else $error("request not in stack segment");
   cpl_pass_a: assert property ($past(resetn) |-> cplOut == $past(cplIn))
      else $error("privilege level altered");
   iopl_pass_a: assert property ($past(resetn) |-> ioplOut == $past(ioplIn))
      else $error("io privilege level altered");
   done_pulse_a: assert property (done |=> !done)
      else $error("done longer than one cycle");
   done_idle_a: assert property (done |-> !busy)
      else $error("busy with done");
   req_hold_a: assert property (memWrite && !memReady |=> memWrite && $stable(memAddr))
      else $error("write dropped before ready");
   one_req_a: assert property (!(memWrite && memRead))
      else $error("read and write together");
   start_take_a: assert property (start && !busy |=> busy)
      else $error("start not taken");
   build_end_a: assert property (start && !busy |-> ##[3:400] done)
      else $error("frame build did not finish");
endmodule
bind nsfb_frame_builder nsfb_frame_builder_monitor mon (.clock(clock), .resetn(resetn),
   .start(start), .busy(busy), .done(done), .memWrite(memWrite), .memRead(memRead),
   .memReady(memReady), .memAddr(memAddr), .memSegment(memSegment), .cplIn(cplIn),
   .ioplIn(ioplIn), .cplOut(cplOut), .ioplOut(ioplOut));

// >>> tb/nsfb_stack_mem.sv
`timescale 1ns/1ps
module nsfb_stack_mem (
   input wire clock,
   input wire resetn,
   input wire [3:0] slowWait,
   input wire memWrite,
   input wire memRead,
   input wire [31:0] memAddr,
   input wire [31:0] memWriteData,
   output reg memReady,
   output reg [31:0] memReadData
);
   // Only the low 64 KiB is decoded; the bench keeps its stacks inside it
   reg [31:0] mem [0:16383];
   reg [3:0] waitCnt;
   // Read data toggles when not valid so a stale value never looks right
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         memReady <= 1'b0;
         memReadData <= 32'h5A5A5A5A;
         waitCnt <= 4'h0;
      end else begin
         memReady <= 1'b0;
         memReadData <= ~memReadData;
         if (memReady || !(memWrite || memRead)) begin
            waitCnt <= 4'h0;
         end else if (waitCnt < slowWait) begin
            waitCnt <= waitCnt + 4'h1;
         end else begin
            memReady <= 1'b1;
            if (memRead) begin
               memReadData <= mem[memAddr[15:2]];
            end
            if (memWrite) begin
               mem[memAddr[15:2]] <= memWriteData;
            end
         end
      end
   end
endmodule

// >>> tb/nsfb_frame_builder_tb.sv
`timescale 1ns/1ps
module nsfb_frame_builder_tb;
   reg clock = 1'b0;
   reg resetn = 1'b0;
   reg start = 1'b0;
   reg [15:0] storageIn = 16'h0000;
   reg [4:0] levelIn = 5'h00;
   reg loadRegs = 1'b0;
   reg [31:0] loadFrameBase = 32'h0;
   reg [31:0] loadStackPtr = 32'h0;
   reg [1:0] cplIn = 2'h0;
   reg [1:0] ioplIn = 2'h0;
   reg [3:0] slowWait = 4'h0;
   wire busy, done, memWrite, memRead, memReady;
   wire [31:0] memAddr, memWriteData, memReadData, frameBaseOut, stackPtrOut;
   wire [1:0] memSegment, cplOut, ioplOut;
   integer err_count = 0;
   integer cmp_count = 0;
   integer k;
   always #25 clock = ~clock;
   nsfb_frame_builder nsfb_frame_builder_inst (.clock(clock), .resetn(resetn), .start(start),
      .storageIn(storageIn), .levelIn(levelIn), .loadRegs(loadRegs),
      .loadFrameBase(loadFrameBase), .loadStackPtr(loadStackPtr), .memReady(memReady),
      .memReadData(memReadData), .cplIn(cplIn), .ioplIn(ioplIn), .busy(busy), .done(done),
      .memWrite(memWrite), .memRead(memRead), .memAddr(memAddr),
      .memWriteData(memWriteData), .memSegment(memSegment), .frameBaseOut(frameBaseOut),
      .stackPtrOut(stackPtrOut), .cplOut(cplOut), .ioplOut(ioplOut));
   nsfb_stack_mem nsfb_stack_mem_inst (.clock(clock), .resetn(resetn), .slowWait(slowWait),
      .memWrite(memWrite), .memRead(memRead), .memAddr(memAddr),
      .memWriteData(memWriteData), .memReady(memReady), .memReadData(memReadData));
   function [31:0] m(input [31:0] a);
      m = nsfb_stack_mem_inst.mem[a[15:2]];
   endfunction
   task poke(input [31:0] a, input [31:0] d);
      begin
         nsfb_stack_mem_inst.mem[a[15:2]] = d;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task final_report;
      begin
         $display("mismatches=%0d compares=%0d", err_count, cmp_count);
         if (err_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask
   // ------------------------------------------------------------
   // Frame build with a poisoned stack area to catch extra pushes
   // ------------------------------------------------------------
   task build(input [15:0] st, input [4:0] lv, input [3:0] w, input bump);
      integer i;
      reg [31:0] top;
      begin
         for (i = 1; i < 36; i = i + 1) poke(32'h10000 - 4 * i, 32'hDEAD0000 + i);
         @(posedge clock);
         loadRegs <= 1'b1;
         loadFrameBase <= 32'h8000;
         loadStackPtr <= 32'h10000;
         slowWait <= w;
         @(posedge clock);
         loadRegs <= 1'b0;
         start <= 1'b1;
         storageIn <= st;
         levelIn <= lv;
         @(posedge clock);
         start <= 1'b0;
         if (bump) begin
            repeat (3) @(posedge clock);
            start <= 1'b1;
            levelIn <= 5'h00;
            @(posedge clock);
            start <= 1'b0;
         end
         i = 0;
         while (done !== 1'b1 && i < 500) begin
            @(negedge clock);
            i = i + 1;
         end
         // A build that never finishes counts here as a mismatch
         chk({31'h0, done}, 32'h00000001);
         top = (lv == 5'h00) ? 32'hFFFC : 32'hFFFC - {25'h0, lv, 2'h0};
         chk(frameBaseOut, 32'hFFFC);
         chk(stackPtrOut, top - {16'h0, st});
         chk(m(32'hFFFC), 32'h8000);
         for (i = 1; i < lv; i = i + 1) chk(m(32'hFFFC - 4 * i), 32'hA0000000 + i);
         if (lv != 5'h00) chk(m(top), 32'hFFFC);
         chk(m(top - 32'h4), 32'hDEAD0000 + (32'h10000 - top) / 4 + 1);
      end
   endtask
   task t_flat;
      begin
         build(16'h0000, 5'h00, 4'h0, 1'b0);
         build(16'h0010, 5'h00, 4'h3, 1'b0);
      end
   endtask
   task t_level1;
      begin
         build(16'h0008, 5'h01, 4'h1, 1'b0);
      end
   endtask
   task t_nested;
      begin
         build(16'h0800, 5'h03, 4'h0, 1'b0);
      end
   endtask
   task t_deep;
      begin
         build(16'hFFFF, 5'h1F, 4'h2, 1'b1);
      end
   endtask
   task t_priv;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            @(posedge clock);
            cplIn <= k[1:0];
            ioplIn <= 2'h3 - k[1:0];
            levelIn <= 5'h1F;
            @(posedge clock);
            @(negedge clock);
            chk({30'h0, cplOut}, k);
            chk({30'h0, ioplOut}, 3 - k);
         end
      end
   endtask
   initial begin
      for (k = 1; k < 32; k = k + 1) poke(32'h8000 - 4 * k, 32'hA0000000 + k);
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      t_flat;
      t_level1;
      t_nested;
      t_deep;
      t_priv;
      final_report;
   end
   initial begin
      #400000;
      err_count = err_count + 1;
      final_report;
   end
endmodule
